// file: icu_defines.svh
`ifndef ICU_DEFINES_SVH
`define ICU_DEFINES_SVH
// Register indices on the plain register port.
`define ICU_ADDR_CTRL1      4'h0
`define ICU_ADDR_CTRL2      4'h1
`define ICU_ADDR_BUF        4'h2
`define ICU_ADDR_TIMER      4'h3
// First control register field positions.
`define ICU_MODE_LSB        0
`define ICU_MODE_MSB        2
`define ICU_NE_BIT          3
`define ICU_INTV_LSB        5
`define ICU_INTV_MSB        6
`define ICU_TSEL_LSB        10
`define ICU_TSEL_MSB        12
// Second control register field positions.
`define ICU_SYNC_LSB        0
`define ICU_SYNC_MSB        4
`define ICU_TSTAT_BIT       6
`define ICU_TRIG_BIT        7
`define ICU_CASC_BIT        8
// Reset values.
`define ICU_CTRL1_RST       16'h0000
`define ICU_CTRL2_RST       16'h0000
`define ICU_SYNC_NONE       5'h00
// Prescale counts for every 4th and every 16th rising edge.
`define ICU_PRE4_LAST       4'h3
`define ICU_PRE16_LAST      4'hf
`endif

// file: icu_pkg.sv
package icu_pkg;
    // Capture mode encodings held in the three-bit mode field.
    typedef enum logic [2:0] {
        ICU_M_OFF    = 3'h0,
        ICU_M_EVERY  = 3'h1,
        ICU_M_RISE   = 3'h3,
        ICU_M_RISE4  = 3'h4,
        ICU_M_RISE16 = 3'h5
    } icu_mode_t;
    // Run state of the capture engine.
    typedef enum logic [1:0] {
        ICU_S_IDLE,
        ICU_S_WAIT,
        ICU_S_RUN
    } icu_state_t;
endpackage : icu_pkg

// file: icu_top.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "icu_defines.svh"
// Summary of operation
// - Capture time base on rising or both edges.
// - Prescale captures to every 4th or 16th rise.
// - Interrupt every event or every Nth event.
// - Not-empty flag shows waiting captured values.
// - Buffer read pops; flag clears when empty.
// - Five-bit sync source select; nonzero needed.
// - Start mode bit; trigger status cleared first.
// - Three-bit mode field selects operating mode.
// - Cascade bit joins odd and even modules.
// - Even module in cascade runs synchronously.
// - Odd module fields govern the pair; the even module still runs on its own mode, time base and source fields.
// - Cascaded sync pair held until source enabled.
// - Capture starts only with time base and source on.
// - Odd supplies low half, even high half.
// - Default is standalone sixteen-bit operation.
// - Odd wrap increments even count in cascade.
module icu_top #(
    parameter int DEPTH = 4,
    parameter int TW    = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         capture_input_odd_i,
    input  wire logic [7:0]   timebase_run_i,
    input  wire logic [31:0]  sync_source_on_i,
    input  wire logic         odd_is_cascaded_i,
    input  wire logic         odd_wrap_i,
    input  wire logic         is_even_i,
    input  wire logic [3:0]   addr_i,
    input  wire logic [15:0]  wdata_i,
    input  wire logic         wr_i,
    input  wire logic         rd_i,
    output logic [15:0]       rdata_o,
    output logic              capture_event_o,
    output logic              interrupt_o,
    output logic              wrap_o
);
    import icu_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [15:0]          ctrl1_q, ctrl1_d;      // First control register.
    logic [15:0]          ctrl2_q, ctrl2_d;      // Second control register.
    logic [TW-1:0]        timer_q, timer_d;      // Own time base count.
    logic [TW-1:0]        mem_q [DEPTH];         // FIFO storage.
    logic [TW-1:0]        mem_d [DEPTH];         // Next FIFO storage.
    logic [AW-1:0]        wp_q, wp_d;            // Write pointer.
    logic [AW-1:0]        rp_q, rp_d;            // Read pointer.
    logic [AW:0]          cnt_q, cnt_d;          // Entries held.
    logic                 pin_q, pin_d;          // Previous pin level.
    logic [3:0]           pre_q, pre_d;          // Edge prescaler.
    logic [1:0]           ev_q, ev_d;            // Events since interrupt.
    icu_state_t           st_q, st_d;            // Run state.
    logic [15:0]          rdata_d;
    logic                 cap_q, cap_d;
    logic                 irq_q, irq_d;
    logic                 wrap_q, wrap_d;

    // Decoded fields.
    logic [2:0] mode;
    logic [1:0] intv;
    logic [2:0] tsel;
    logic [4:0] ssel;
    logic       trig, casc, tb_on, src_on, rise, fall, qual, push, pop;

    always_comb
    begin
        mode   = ctrl1_q[`ICU_MODE_MSB:`ICU_MODE_LSB];
        intv   = ctrl1_q[`ICU_INTV_MSB:`ICU_INTV_LSB];
        tsel   = ctrl1_q[`ICU_TSEL_MSB:`ICU_TSEL_LSB];
        ssel   = ctrl2_q[`ICU_SYNC_MSB:`ICU_SYNC_LSB];
        casc   = ctrl2_q[`ICU_CASC_BIT];
        // The even half in cascade is forced to sync mode; its own trigger bit is ignored.
        trig   = ctrl2_q[`ICU_TRIG_BIT] & ~(casc & is_even_i);
        tb_on  = timebase_run_i[tsel];
        // Source zero means no source, so the unit never starts on it.
        src_on = (ssel != `ICU_SYNC_NONE) & sync_source_on_i[ssel];
        rise   = capture_input_odd_i & ~pin_q;
        fall   = ~capture_input_odd_i & pin_q;
        pop    = rd_i & (addr_i == `ICU_ADDR_BUF) & (cnt_q != '0);
    end

    // Run state: wait for the chosen time base and source.
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ICU_S_IDLE:
            begin
                // Mode off parks the engine.
                if (mode != ICU_M_OFF)
                    st_d = ICU_S_WAIT;
            end
            ICU_S_WAIT:
            begin
                // Held until both enables are present.
                if (mode == ICU_M_OFF)
                    st_d = ICU_S_IDLE;
                else if (tb_on & src_on)
                    st_d = ICU_S_RUN;
            end
            ICU_S_RUN:
            begin
                // Sync mode drops back when source goes away; trigger
                // mode stays armed once fired.
                if (mode == ICU_M_OFF)
                    st_d = ICU_S_IDLE;
                else if (!trig && !src_on)
                    st_d = ICU_S_WAIT;
            end
            default: st_d = ICU_S_IDLE;
        endcase
    end

    // Edge qualification and prescale.
    always_comb
    begin
        pin_d = capture_input_odd_i;
        pre_d = pre_q;
        qual  = 1'b0;
        if (st_q != ICU_S_RUN)
            pre_d = 4'h0;
        else
        begin
            case (mode)
                ICU_M_EVERY: qual = rise | fall;
                ICU_M_RISE:  qual = rise;
                ICU_M_RISE4, ICU_M_RISE16:
                begin
                    // Prescaler counts rises, fires on the last one.
                    if (rise)
                    begin
                        if (pre_q == ((mode == ICU_M_RISE4) ?
                            `ICU_PRE4_LAST : `ICU_PRE16_LAST))
                        begin
                            qual  = 1'b1;
                            pre_d = 4'h0;
                        end
                        else
                            pre_d = pre_q + 4'h1;
                    end
                end
                default: qual = 1'b0;
            endcase
        end
        // Full FIFO drops the capture rather than overwriting.
        push = qual & (cnt_q != DEPTH[AW:0]);
    end

    // Time base count, FIFO and interrupt decimation.
    always_comb
    begin
        timer_d = timer_q;
        wrap_d  = 1'b0;
        if (st_q == ICU_S_RUN)
        begin
            // Even half of a pair counts odd wraps only.
            if (!(casc && is_even_i) || odd_wrap_i)
            begin
                timer_d = timer_q + 1'b1;
                wrap_d  = &timer_q;
            end
        end
        else if (casc)
            timer_d = '0;
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        if (push)
        begin
            mem_d[wp_q] = timer_q;
            wp_d        = wp_q + 1'b1;
        end
        if (pop)
            rp_d = rp_q + 1'b1;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        cap_d = push;
        irq_d = 1'b0;
        ev_d  = ev_q;
        // Interval code n raises the interrupt every n+1 events.
        if (push && !(casc && is_even_i))
        begin
            // A count already past a newly lowered code fires on the next capture,
            // so lowering the interval while running never stalls it.
            if (ev_q >= intv)
            begin
                irq_d = 1'b1;
                ev_d  = 2'h0;
            end
            else
                ev_d = ev_q + 2'h1;
        end
        if (st_q != ICU_S_RUN)
            ev_d = 2'h0;
    end

    // Register writes; trigger status is set by hardware on firing.
    always_comb
    begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        if (wr_i && addr_i == `ICU_ADDR_CTRL1)
        begin
            ctrl1_d = wdata_i;
            ctrl1_d[`ICU_NE_BIT] = 1'b0;
        end
        if (wr_i && addr_i == `ICU_ADDR_CTRL2)
            ctrl2_d = wdata_i;
        // A firing in the cycle of a clear still sets the status.
        if (trig && st_q == ICU_S_WAIT && st_d == ICU_S_RUN)
            ctrl2_d[`ICU_TSTAT_BIT] = 1'b1;
        rdata_d = 16'h0000;
        if (rd_i)
        begin
            case (addr_i)
                `ICU_ADDR_CTRL1:
                begin
                    rdata_d = ctrl1_q;
                    rdata_d[`ICU_NE_BIT] = (cnt_q != '0);
                end
                `ICU_ADDR_CTRL2: rdata_d = ctrl2_q;
                `ICU_ADDR_BUF:   rdata_d = (cnt_q != '0) ?
                                           16'(mem_q[rp_q]) : 16'h0000;
                `ICU_ADDR_TIMER: rdata_d = 16'(timer_q);
                default:         rdata_d = 16'h0000;
            endcase
        end
    end

    // All state registers.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl1_q <= `ICU_CTRL1_RST;
            ctrl2_q <= `ICU_CTRL2_RST;
            timer_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            pin_q   <= 1'b0;
            pre_q   <= 4'h0;
            ev_q    <= 2'h0;
            st_q    <= ICU_S_IDLE;
            rdata_o <= 16'h0000;
            cap_q   <= 1'b0;
            irq_q   <= 1'b0;
            wrap_q  <= 1'b0;
        end
        else
        begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            timer_q <= timer_d;
            mem_q   <= mem_d;
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            pin_q   <= pin_d;
            pre_q   <= pre_d;
            ev_q    <= ev_d;
            st_q    <= st_d;
            rdata_o <= rdata_d;
            cap_q   <= cap_d;
            irq_q   <= irq_d;
            wrap_q  <= wrap_d;
        end
    end

    assign capture_event_o = cap_q;
    assign interrupt_o     = irq_q;
    assign wrap_o          = wrap_q;

    // A full FIFO must not grow.
    a_fifo_no_over: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cnt_q <= DEPTH[AW:0]) else $error("fifo count above depth");
    // Not-empty flag readback tracks occupancy.
    a_ne_flag_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `ICU_ADDR_CTRL1 |=>
        rdata_o[`ICU_NE_BIT] == ($past(cnt_q) != 0))
        else $error("not-empty flag wrong");
    // A pop lowers the count when nothing is pushed.
    a_pop_lowers: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pop && !push |=> cnt_q == $past(cnt_q) - 1)
        else $error("pop did not lower count");
    // Captures only happen while running.
    a_cap_run_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        capture_event_o |-> $past(st_q) == ICU_S_RUN)
        else $error("capture outside run");
    // Interval code zero interrupts on every capture.
    a_irq_every: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        push && intv == 2'h0 && !(casc && is_even_i) && st_q == ICU_S_RUN
        |=> interrupt_o) else $error("missed interrupt");
    // Rising-only mode ignores falling edges.
    a_rise_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_q == ICU_S_RUN && mode == ICU_M_RISE && fall |=> !capture_event_o)
        else $error("fall captured");
    // Zero source never moves from waiting to running.
    a_src_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_q == ICU_S_WAIT && ssel == 5'h00 |=> st_q != ICU_S_RUN)
        else $error("started on source zero");
    // Even half in cascade counts only on odd wraps.
    a_even_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_q == ICU_S_RUN && casc && is_even_i && !odd_wrap_i &&
        st_d == ICU_S_RUN |=> $stable(timer_q))
        else $error("even half counted");
endmodule : icu_top

// file: icu_edge_src.sv
`timescale 1ns/1ps
// Stand-in for the external edge source on the capture pin.
module icu_edge_src (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic fire_i,
    output logic      pin_o
);
    logic [2:0] cnt_q; // Cycles left in the high phase.
    logic [2:0] cnt_d; // Next value of the high-phase count.
    // A request starts one clean pulse of four cycles high.
    always_comb
    begin
        cnt_d = (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
        if (fire_i)
        begin
            cnt_d = 3'h4;
        end
    end
    // Registered so the pin only moves just after a clock edge.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 3'h0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
    // The pin idles low, so every pulse gives one rise and one fall.
    assign pin_o = (cnt_q != 3'h0);
endmodule : icu_edge_src

// file: tb_top.sv
`timescale 1ns/1ps
`include "icu_defines.svh"
// Self-checking bench for the capture unit, run standalone.
module tb_top;
    logic        mclk    = 1'b0;   // System clock.
    logic        rst_n   = 1'b0;   // Active-low reset.
    logic        fire    = 1'b0;   // Edge request to the pin model.
    logic        wr      = 1'b0;   // Write strobe.
    logic        rd      = 1'b0;   // Read strobe.
    logic [3:0]  addr    = 4'h0;   // Register index.
    logic [15:0] wdata   = 16'h0;  // Write data.
    logic [7:0]  tb_run  = 8'h00;  // Time base running flags.
    logic [31:0] sync_on = 32'h0;  // Sync source enables.
    logic [15:0] ev_cnt;           // Stored captures seen.
    logic [15:0] irq_cnt;          // Interrupt pulses seen.
    logic [15:0] wrap_cnt;         // Count wrap pulses seen.
    logic        wrap;             // Count wrap pulse.
    logic        pin;              // Capture pin level.
    logic [15:0] rdata;            // Read data.
    logic        cap_ev;           // Capture pulse.
    logic        irq;              // Interrupt pulse.
    int          err_count = 0;    // Mismatches.
    int          checked   = 0;    // Comparisons.
    icu_top u_icu_top (.mclk_i(mclk), .rst_n_i(rst_n),
        .capture_input_odd_i(pin), .timebase_run_i(tb_run),
        .sync_source_on_i(sync_on), .odd_is_cascaded_i(1'b0),
        .odd_wrap_i(1'b0), .is_even_i(1'b0), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .capture_event_o(cap_ev), .interrupt_o(irq), .wrap_o(wrap));
    icu_edge_src u_icu_edge_src (.mclk_i(mclk), .rst_n_i(rst_n),
        .fire_i(fire), .pin_o(pin));
    // Free-running 50 ns clock.
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    // Pulse counters; a pulse that is unknown is not counted.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_cnt   <= 16'h0;
            irq_cnt  <= 16'h0;
            wrap_cnt <= 16'h0;
        end
        else
        begin
            if (cap_ev === 1'b1) ev_cnt <= ev_cnt + 16'h1;
            if (irq === 1'b1) irq_cnt <= irq_cnt + 16'h1;
            if (wrap === 1'b1) wrap_cnt <= wrap_cnt + 16'h1;
        end
    end
    task automatic final_report;
        if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        // One idle edge keeps a following write from reassigning wr.
        @(posedge mclk);
    endtask : reg_wr
    // Read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask : reg_rd
    // Rises are eight cycles apart, four high and four low.
    task automatic fire_n(input int n);
        for (int i = 0; i < n; i++)
        begin
            fire <= 1'b1;
            @(posedge mclk);
            fire <= 1'b0;
            repeat (7) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask : fire_n
    // Pops n entries, then expects an empty flag and a zero read.
    task automatic drain(input int n);
        logic [15:0] d;
        for (int i = 0; i < n; i++) reg_rd(`ICU_ADDR_BUF, d);
        reg_rd(`ICU_ADDR_CTRL1, d);
        cmp(d & 16'h0008, 16'h0000);
        reg_rd(`ICU_ADDR_BUF, d);
        cmp(d, 16'h0000);
    endtask : drain
    // Reset values and an unmapped index.
    task automatic t_reset;
        logic [15:0] d;
        reg_rd(`ICU_ADDR_CTRL1, d);
        cmp(d, `ICU_CTRL1_RST);
        reg_rd(`ICU_ADDR_CTRL2, d);
        cmp(d, `ICU_CTRL2_RST);
        reg_rd(4'h9, d);
        cmp(d, 16'h0000);
    endtask : t_reset
    // No capture until the source is on; then stamps eight apart.
    task automatic t_gate;
        logic [15:0] d;
        logic [15:0] a;
        reg_wr(`ICU_ADDR_CTRL2, 16'h0002);
        reg_wr(`ICU_ADDR_CTRL1, 16'h0403);
        tb_run <= 8'h02;
        fire_n(1);
        reg_rd(`ICU_ADDR_CTRL1, d);
        cmp(d, 16'h0403);
        sync_on <= 32'h4;
        repeat (4) @(posedge mclk);
        fire_n(2);
        reg_rd(`ICU_ADDR_CTRL1, d);
        cmp(d, 16'h040b);
        reg_rd(`ICU_ADDR_BUF, a);
        reg_rd(`ICU_ADDR_BUF, d);
        cmp(d - a, 16'h0008);
        drain(0);
    endtask : t_gate
    // Six rises into four places; one interrupt per capture.
    task automatic t_full;
        logic [15:0] e0;
        logic [15:0] i0;
        e0 = ev_cnt;
        i0 = irq_cnt;
        fire_n(6);
        cmp(ev_cnt - e0, 16'h0004);
        cmp(irq_cnt - i0, 16'h0004);
        drain(4);
    endtask : t_full
    // Every transition, every fourth rise, every sixteenth rise.
    task automatic t_prescale;
        logic [2:0]  mode [3] = '{3'h1, 3'h4, 3'h5};
        int          nf   [3] = '{2, 8, 16};
        logic [15:0] nexp [3] = '{16'h4, 16'h2, 16'h1};
        logic [15:0] e0;
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(`ICU_ADDR_CTRL1, {13'h0080, mode[i]});
            e0 = ev_cnt;
            fire_n(nf[i]);
            cmp(ev_cnt - e0, nexp[i]);
            drain(int'(nexp[i]));
        end
    endtask : t_prescale
    // Interval code one gives an interrupt every second capture.
    task automatic t_interval;
        logic [15:0] i0;
        reg_wr(`ICU_ADDR_CTRL1, 16'h0423);
        i0 = irq_cnt;
        fire_n(4);
        cmp(irq_cnt - i0, 16'h0002);
        drain(4);
    endtask : t_interval
    // Trigger mode: status set on firing, keeps running without source.
    task automatic t_trig;
        logic [15:0] d;
        logic [15:0] e0;
        reg_wr(`ICU_ADDR_CTRL1, 16'h0400);
        sync_on <= 32'h0;
        reg_wr(`ICU_ADDR_CTRL2, 16'h0082);
        reg_wr(`ICU_ADDR_CTRL1, 16'h0403);
        reg_rd(`ICU_ADDR_CTRL2, d);
        cmp(d, 16'h0082);
        sync_on <= 32'h4;
        repeat (4) @(posedge mclk);
        reg_rd(`ICU_ADDR_CTRL2, d);
        cmp(d, 16'h00c2);
        sync_on <= 32'h0;
        repeat (4) @(posedge mclk);
        e0 = ev_cnt;
        fire_n(1);
        cmp(ev_cnt - e0, 16'h0001);
        drain(1);
    endtask : t_trig
    // Own count read back, then one wrap pulse as it rolls over.
    task automatic t_wrap;
        logic [15:0] t0;
        logic [15:0] w0;
        w0 = wrap_cnt;
        reg_rd(`ICU_ADDR_TIMER, t0);
        repeat (int'(16'hffff - t0) + 4) @(posedge mclk);
        cmp(wrap_cnt - w0, 16'h0001);
    endtask : t_wrap
    // Main sequence: three cycles of reset, then the scenarios.
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_gate();
        t_full();
        t_prescale();
        t_interval();
        t_trig();
        t_wrap();
        final_report();
    end
    // The scenarios need about 66,000 cycles, most spent waiting for
    // the count to wrap, so the limit leaves a wide margin.
    initial
    begin
        #(80000 * 50);
        err_count++;
        final_report();
    end
endmodule : tb_top
